// ---- rtl/fsr_status_regs.sv ----
// Function
// - Byte-two write changes only bits four, three
// - Bit four enables the soft reset command
// - Bit three enables lockdown and freeze commands
// - Bit two shows a program suspended sector
// - Bit one shows an erase suspended sector
// - Bit zero is busy during self-timed work
// - Lock bit blocks all sector protection changes
// - Lock bit clears at power-up, survives reset
// - Protect pin asserted: lock bit only sets
// - Byte-one write alters only the lock bit
// - Failure flag updated after every non-aborted program/erase
// - Aborted operations never set the failure flag
// - Read-only bit mirrors the protect pin
// - Two-bit summary: none, some, all protected
// - Clear latch rejects every write-type command
// - Latch clear after power-up and reset
// - Latch clears when gated operations end
// - Partial opcode abort leaves latch set
// - Reset enable held until byte-two write
// - Lockdown enable held, soft reset ignores it
// - Freeze forces lockdown enable low forever
// - Opcode 05h streams both bytes repeatedly
// - Byte one field layout as listed
// - Summary codes 00, 01, 11; 10 reserved
// - Busy bit in both bytes, refreshed per byte
`timescale 1ns/1ps
module fsr_status_regs
    import fsr_pkg::*;
(
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Decoder events and array status
    input wire fsr_cmd_t i_cmd,
    input wire fsr_core_t i_core,
    // Write-protect pin, active low, asynchronous
    input wire logic i_wp_n,
    // Serial link pins
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_si,
    output logic o_spi_so,
    output logic o_spi_so_oe_n,
    // Status and gating to the decoder
    output fsr_gate_t o_gate,
    output logic [7:0] o_status_one,
    output logic [7:0] o_status_two
);

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Summary code from the per-sector protection levels
    function automatic logic [1:0] swp_code(input logic any,
                                            input logic all);
        logic [1:0] code;
        code = SWP_NONE;
        if (all) begin
            code = SWP_ALL;
        end else if (any) begin
            code = SWP_SOME;
        end
        return code;
    endfunction : swp_code

    // ---------------------------------------------------------------
    // Protect pin synchroniser
    // ---------------------------------------------------------------
    logic wp_s1_reg;
    logic wp_n_reg;

    // Pin is idle high, so the chain resets to deasserted
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wp_s1_reg <= 1'h1;
            wp_n_reg <= 1'h1;
        end else begin
            wp_s1_reg <= i_wp_n;
            wp_n_reg <= wp_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Write enable latch
    // ---------------------------------------------------------------
    logic wel_reg;
    logic wel_clear;
    logic soft_reset_enable_reg;
    logic soft_reset_hit;

    // Soft reset only counts when it was enabled
    assign soft_reset_hit = i_cmd.soft_reset_done & soft_reset_enable_reg;
    // Decoder pulses gated_end only after a whole gated opcode,
    // so a partial opcode never reaches this term
    assign wel_clear = i_cmd.wr_disable | i_cmd.gated_end
        | i_cmd.wsr1_commit | i_cmd.wsr2_commit
        | i_cmd.hold_abort | soft_reset_hit;

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wel_reg <= RST_WEL;
        end else if (i_cmd.wr_enable) begin
            wel_reg <= 1'h1;
        end else if (wel_clear) begin
            wel_reg <= 1'h0;
        end
    end

    // ---------------------------------------------------------------
    // Protection lock bit
    // ---------------------------------------------------------------
    logic lock_reg;
    logic lock_wr_ok;

    // Clearing is refused while the pin is asserted
    assign lock_wr_ok = i_cmd.wsr1_commit & wel_reg
        & (wp_n_reg | i_cmd.wr_data[ONE_LOCK_BIT]);

    // Soft reset is deliberately not a term here
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            lock_reg <= RST_LOCK;
        end else if (lock_wr_ok) begin
            lock_reg <= i_cmd.wr_data[ONE_LOCK_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Program/erase failure flag
    // ---------------------------------------------------------------
    logic fail_reg;

    // Aborted runs leave the previous verdict in place
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            fail_reg <= RST_FAIL;
        end else if (i_cmd.pe_done && !i_cmd.pe_aborted) begin
            fail_reg <= i_cmd.pe_fail;
        end
    end

    // ---------------------------------------------------------------
    // Reset enable, lockdown enable and freeze
    // ---------------------------------------------------------------
    logic sle_reg;
    logic frozen_reg;
    logic wsr2_ok;

    assign wsr2_ok = i_cmd.wsr2_commit & wel_reg;

    // Only the byte-two write moves the reset enable
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            soft_reset_enable_reg <= RST_SOFT_RESET_ENABLE;
        end else if (wsr2_ok) begin
            soft_reset_enable_reg <= i_cmd.wr_data[TWO_SOFT_RESET_ENABLE_BIT];
        end
    end

    // Freeze is sticky until power is cycled
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            frozen_reg <= 1'h0;
        end else if (i_cmd.freeze_done && sle_reg && wel_reg) begin
            frozen_reg <= 1'h1;
        end
    end

    // Frozen state overrides any later byte-two write
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sle_reg <= RST_SLE;
        end else if (frozen_reg || i_cmd.freeze_done && sle_reg
                     && wel_reg) begin
            sle_reg <= 1'h0;
        end else if (wsr2_ok) begin
            sle_reg <= i_cmd.wr_data[TWO_SLE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Gating levels toward the decoder
    // ---------------------------------------------------------------
    assign o_gate.gated_cmds_ok = wel_reg;
    assign o_gate.soft_reset_ok = soft_reset_enable_reg;
    assign o_gate.lockdown_ok = sle_reg & wel_reg;
    assign o_gate.prot_cmds_ok = ~lock_reg & wel_reg;

    // ---------------------------------------------------------------
    // Assembled status bytes
    // ---------------------------------------------------------------
    logic [7:0] one_next;
    logic [7:0] two_next;
    logic [7:0] one_reg;
    logic [7:0] two_reg;

    // Live view, reserved bits tied low
    always_comb begin
        one_next = RST_BYTE;
        one_next[ONE_LOCK_BIT] = lock_reg;
        one_next[ONE_FAIL_BIT] = fail_reg;
        one_next[ONE_PIN_BIT] = wp_n_reg;
        one_next[ONE_SWP_HI:ONE_SWP_LO] =
            swp_code(i_core.prot_any, i_core.prot_all);
        one_next[ONE_WEL_BIT] = wel_reg;
        one_next[READY_BUSY_BIT] = i_core.busy;
        two_next = RST_BYTE;
        two_next[TWO_SOFT_RESET_ENABLE_BIT] = soft_reset_enable_reg;
        two_next[TWO_SLE_BIT] = sle_reg;
        two_next[TWO_PS_BIT] = i_core.prog_susp;
        two_next[TWO_ES_BIT] = i_core.erase_susp;
        two_next[READY_BUSY_BIT] = i_core.busy;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            one_reg <= RST_BYTE;
            two_reg <= RST_BYTE;
        end else begin
            one_reg <= one_next;
            two_reg <= two_next;
        end
    end

    assign o_status_one = one_reg;
    assign o_status_two = two_reg;

    // ---------------------------------------------------------------
    // Snapshot hand-off to the link clock
    // ---------------------------------------------------------------
    // Toggle handshake: the snapshot only moves while the link side
    // has acknowledged, so it is stable whenever the link copies it.
    logic [15:0] snap_reg;
    logic push_reg;
    logic ack_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ack_s1_reg <= 1'h0;
            ack_s2_reg <= 1'h0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            snap_reg <= {RST_BYTE, RST_BYTE};
            push_reg <= 1'h0;
        end else if (push_reg == ack_s2_reg) begin
            snap_reg <= {one_reg, two_reg};
            push_reg <= ~push_reg;
        end
    end

    // ---------------------------------------------------------------
    // Link side: snapshot capture
    // ---------------------------------------------------------------
    // The link clock stops outside frames; a snapshot that arrives
    // between frames is picked up three edges into the next one.
    logic push_s1_reg;
    logic push_s2_reg;
    logic [15:0] shadow_reg;

    always_ff @(posedge i_spi_sclk or posedge i_reset) begin
        if (i_reset) begin
            push_s1_reg <= 1'h0;
            push_s2_reg <= 1'h0;
        end else begin
            push_s1_reg <= push_reg;
            push_s2_reg <= push_s1_reg;
        end
    end

    always_ff @(posedge i_spi_sclk or posedge i_reset) begin
        if (i_reset) begin
            shadow_reg <= {RST_BYTE, RST_BYTE};
            ack_reg <= 1'h0;
        end else if (push_s2_reg != ack_reg) begin
            shadow_reg <= snap_reg;
            ack_reg <= push_s2_reg;
        end
    end

    // ---------------------------------------------------------------
    // Link side: opcode and byte stream
    // ---------------------------------------------------------------
    logic frame_rst;
    logic [6:0] op_sh_reg;
    logic [2:0] bit_cnt_reg;
    logic op_done_reg;
    logic rd_act_reg;
    logic sel_two_reg;
    logic [7:0] out_byte_reg;

    // Chip select high ends the frame at once
    assign frame_rst = i_reset | i_spi_cs_n;

    // Rising edge: opcode shift and bit count
    always_ff @(posedge i_spi_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            op_sh_reg <= 7'h00;
            bit_cnt_reg <= 3'h0;
            op_done_reg <= 1'h0;
            rd_act_reg <= 1'h0;
        end else begin
            op_sh_reg <= {op_sh_reg[5:0], i_spi_si};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7 && !op_done_reg) begin
                op_done_reg <= 1'h1;
                rd_act_reg <= ({op_sh_reg, i_spi_si}
                               == OP_READ_STATUS);
            end
        end
    end

    // Byte loader: alternates byte one and byte two, each fresh
    always_ff @(posedge i_spi_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            sel_two_reg <= 1'h0;
            out_byte_reg <= RST_BYTE;
        end else if (bit_cnt_reg == 3'h7) begin
            out_byte_reg <= sel_two_reg ? shadow_reg[7:0]
                                        : shadow_reg[15:8];
            sel_two_reg <= ~sel_two_reg;
        end
    end

    // Falling edge: drive the data pin, most significant bit first
    always_ff @(negedge i_spi_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            o_spi_so <= 1'h0;
            o_spi_so_oe_n <= 1'h1;
        end else begin
            o_spi_so <= out_byte_reg[3'h7 - bit_cnt_reg];
            o_spi_so_oe_n <= ~rd_act_reg;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_wel_set_cmd: assert property (@(posedge i_clk_sys)
        disable iff (i_reset) i_cmd.wr_enable |=> wel_reg)
        else $error("write enable did not set latch");

    a_wel_auto_clear: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        (i_cmd.gated_end || i_cmd.wr_disable || i_cmd.hold_abort)
        && !i_cmd.wr_enable |=> !wel_reg ##1 !o_status_one[1])
        else $error("latch not cleared after gated end");

    a_lock_pin_hold: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        lock_reg && !wp_n_reg && i_cmd.wsr1_commit
        && !i_cmd.wr_data[7] |=> lock_reg)
        else $error("lock cleared while pin asserted");

    a_lock_only_wsr1: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        !i_cmd.wsr1_commit |=> $stable(lock_reg))
        else $error("lock changed without byte-one write");

    a_fail_no_abort: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        i_cmd.pe_done && i_cmd.pe_aborted |=> $stable(fail_reg))
        else $error("abort altered failure flag");

    a_fail_follows: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        i_cmd.pe_done && !i_cmd.pe_aborted
        |=> ##1 o_status_one[5] == $past(i_cmd.pe_fail, 2))
        else $error("failure flag not updated");

    a_soft_reset_enable_only_wsr2: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        !i_cmd.wsr2_commit |=> $stable(soft_reset_enable_reg))
        else $error("reset enable changed unexpectedly");

    a_frozen_sle_low: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        frozen_reg |=> !sle_reg && !o_gate.lockdown_ok)
        else $error("lockdown enabled after freeze");

    a_byte_two_rsvd: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        o_status_two[7:5] == 3'h0 && o_status_one[6] == 1'h0)
        else $error("reserved status bits nonzero");

    a_swp_encode: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        i_core.prot_all |=> o_status_one[3:2] == SWP_ALL)
        else $error("summary code wrong for all protected");

    a_busy_both: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        o_status_one[0] == o_status_two[0])
        else $error("busy bit differs between bytes");

endmodule : fsr_status_regs

// ---- rtl/fsr_pkg.sv ----
package fsr_pkg;

    // ---------------------------------------------------------------
    // Status byte one field positions
    // ---------------------------------------------------------------
    localparam int unsigned ONE_LOCK_BIT = 7;
    localparam int unsigned ONE_FAIL_BIT = 5;
    localparam int unsigned ONE_PIN_BIT = 4;
    localparam int unsigned ONE_SWP_HI = 3;
    localparam int unsigned ONE_SWP_LO = 2;
    localparam int unsigned ONE_WEL_BIT = 1;
    localparam int unsigned READY_BUSY_BIT = 0;

    // ---------------------------------------------------------------
    // Status byte two field positions
    // ---------------------------------------------------------------
    localparam int unsigned TWO_SOFT_RESET_ENABLE_BIT = 4;
    localparam int unsigned TWO_SLE_BIT = 3;
    localparam int unsigned TWO_PS_BIT = 2;
    localparam int unsigned TWO_ES_BIT = 1;

    // ---------------------------------------------------------------
    // Encodings, opcode and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_SOME = 2'h1;
    localparam logic [1:0] SWP_ALL = 2'h3;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic RST_LOCK = 1'h0;
    localparam logic RST_FAIL = 1'h0;
    localparam logic RST_WEL = 1'h0;
    localparam logic RST_SOFT_RESET_ENABLE = 1'h0;
    localparam logic RST_SLE = 1'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Command events from the opcode decoder, one-cycle pulses
    typedef struct packed {
        logic wr_enable;
        logic wr_disable;
        logic wsr1_commit;
        logic wsr2_commit;
        logic [7:0] wr_data;
        logic gated_end;
        logic hold_abort;
        logic pe_done;
        logic pe_fail;
        logic pe_aborted;
        logic freeze_done;
        logic soft_reset_done;
    } fsr_cmd_t;

    // Levels from the array controller
    typedef struct packed {
        logic busy;
        logic prog_susp;
        logic erase_susp;
        logic prot_any;
        logic prot_all;
    } fsr_core_t;

    // Gating levels back to the command decoder
    typedef struct packed {
        logic gated_cmds_ok;
        logic soft_reset_ok;
        logic lockdown_ok;
        logic prot_cmds_ok;
    } fsr_gate_t;

endpackage : fsr_pkg

// ---- tb/fsr_spi_host.sv ----
`timescale 1ns/1ps
module fsr_spi_host (
    // Link pins towards the device
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    // Device answer
    input wire logic i_so,
    input wire logic i_so_oe_n
);
    // ---------------------------------------------------------------
    // Idle: clock parked low outside frames, select released
    // ---------------------------------------------------------------
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    // One frame: opcode MSB first, then four bytes clocked out.
    // SI toggles after the opcode so no stale level lingers on it.
    task automatic frame(input logic [7:0] op, output logic [31:0] rx,
                         output logic oe_any);
        oe_any = 1'b0;
        o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            o_si = op[i];
            #16 o_sclk = 1'b1;
            #16 o_sclk = 1'b0;
        end
        for (int i = 31; i >= 0; i--) begin
            o_si = ~o_si;
            #16 o_sclk = 1'b1;
            rx[i] = i_so;
            oe_any = oe_any | ~i_so_oe_n;
            #16 o_sclk = 1'b0;
        end
        #16 o_cs_n = 1'b1;
        // Idle gap so a following frame never sees a zero-width deselect
        #32;
    endtask : frame
endmodule : fsr_spi_host

// ---- tb/fsr_status_regs_tb_top.sv ----
`timescale 1ns/1ps
module fsr_status_regs_tb_top
    import fsr_pkg::*;
;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    fsr_cmd_t cmd = '0;
    fsr_core_t core = '0;
    logic wp_n = 1'b1;
    logic sclk, cs_n, si, so, so_oe_n;
    fsr_gate_t gate;
    logic [7:0] st1, st2;
    int n_fail = 0;
    int samples_checked = 0;
    localparam fsr_cmd_t WEN = '{wr_enable: 1'b1, default: '0};
    localparam fsr_cmd_t SRST = '{soft_reset_done: 1'b1, default: '0};
    localparam fsr_cmd_t FRZ = '{freeze_done: 1'b1, default: '0};

    // 10 MHz system clock
    always #50 i_clk_sys = ~i_clk_sys;

    fsr_status_regs DUT (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cmd(cmd),
        .i_core(core), .i_wp_n(wp_n), .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n), .i_spi_si(si), .o_spi_so(so),
        .o_spi_so_oe_n(so_oe_n), .o_gate(gate), .o_status_one(st1),
        .o_status_two(st2)
    );

    fsr_spi_host u_host (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so),
        .i_so_oe_n(so_oe_n)
    );

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // Inputs move 5 ns after the edge, clear of the sampling point
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #5;
    endtask : tick

    // One-cycle event, then enough edges for the registered outputs
    task automatic send(input fsr_cmd_t c);
        cmd = c;
        tick(1);
        cmd = '0;
        tick(3);
    endtask : send

    task automatic wsr(input bit two, input logic [7:0] d);
        fsr_cmd_t c;
        c = '0;
        c.wr_data = d;
        if (two) begin
            c.wsr2_commit = 1'b1;
        end else begin
            c.wsr1_commit = 1'b1;
        end
        send(c);
    endtask : wsr

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        chk("one", 8'h10, st1);
        chk("two", 8'h00, st2);
        chk("gate", 8'h00, {4'h0, gate});
    endtask : t_reset

    // Latch set and every way of clearing it except the byte-one write
    task automatic t_wel;
        fsr_cmd_t clr[3];
        clr[0] = '{wr_disable: 1'b1, default: '0};
        clr[1] = '{gated_end: 1'b1, default: '0};
        clr[2] = '{hold_abort: 1'b1, default: '0};
        send(WEN);
        chk("one", 8'h12, st1);
        chk("gate", 8'h09, {4'h0, gate});
        wsr(1'b1, 8'hFF);
        chk("two", 8'h18, st2);
        chk("one", 8'h10, st1);
        wsr(1'b1, 8'h00);
        chk("two", 8'h18, st2);
        chk("gate", 8'h04, {4'h0, gate});
        send(WEN);
        chk("gate", 8'h0F, {4'h0, gate});
        send(SRST);
        chk("two", 8'h18, st2);
        chk("one", 8'h10, st1);
        for (int k = 0; k < 3; k++) begin
            send(WEN);
            send(clr[k]);
            chk("one", 8'h10, st1);
        end
        send(WEN);
        wsr(1'b1, 8'h00);
        chk("two", 8'h00, st2);
    endtask : t_wel

    // Lock bit against the protect pin
    task automatic t_lock;
        send(WEN);
        wsr(1'b0, 8'hFF);
        chk("one", 8'h90, st1);
        send(SRST);
        chk("one", 8'h90, st1);
        send(WEN);
        chk("gate", 8'h08, {4'h0, gate});
        wp_n = 1'b0;
        tick(6);
        chk("one", 8'h82, st1);
        wsr(1'b0, 8'h00);
        chk("one", 8'h80, st1);
        wp_n = 1'b1;
        tick(6);
        send(WEN);
        wsr(1'b0, 8'h00);
        chk("one", 8'h10, st1);
    endtask : t_lock

    // Failure flag: fail, abort, pass, abort with fail
    task automatic t_fail;
        fsr_cmd_t c;
        logic [3:0] f;
        logic [3:0] a;
        f = 4'b1001;
        a = 4'b1010;
        for (int i = 0; i < 4; i++) begin
            c = '0;
            c.pe_done = 1'b1;
            c.pe_fail = f[i];
            c.pe_aborted = a[i];
            send(c);
            chk("one", (i < 2) ? 8'h30 : 8'h10, st1);
        end
    endtask : t_fail

    // Array status levels into both bytes
    task automatic t_core;
        logic [4:0] cv[5];
        logic [7:0] e1[5];
        logic [7:0] e2[5];
        cv = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h03};
        e1 = '{8'h11, 8'h10, 8'h10, 8'h14, 8'h1C};
        e2 = '{8'h01, 8'h04, 8'h02, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            core = cv[i];
            tick(4);
            chk("one", e1[i], st1);
            chk("two", e2[i], st2);
        end
        core = '0;
        tick(4);
    endtask : t_core

    // Freeze is permanent, so this runs after all other LOCKDOWN_ENABLE checks
    task automatic t_freeze;
        send(WEN);
        wsr(1'b1, 8'h08);
        chk("two", 8'h08, st2);
        send(WEN);
        chk("gate", 8'h0B, {4'h0, gate});
        send(FRZ);
        chk("two", 8'h00, st2);
        send(WEN);
        wsr(1'b1, 8'h18);
        chk("two", 8'h10, st2);
    endtask : t_freeze

    // Status over the link while busy, then poll until ready
    task automatic t_spi;
        logic [31:0] rx;
        logic oe;
        int n;
        core.busy = 1'b1;
        tick(4);
        u_host.frame(OP_READ_STATUS, rx, oe);
        chk("oe", 8'h01, {7'h0, oe});
        chk("spi one", 8'h11, rx[15:8]);
        chk("spi two", 8'h11, rx[7:0]);
        tick(1);
        core.busy = 1'b0;
        n = 0;
        // Keep reading until busy drops, bounded
        do begin
            u_host.frame(OP_READ_STATUS, rx, oe);
            n++;
        end while (rx[8] !== 1'b0 && n < 8);
        chk("spi one", 8'h10, rx[15:8]);
        chk("spi two", 8'h10, rx[7:0]);
        u_host.frame(8'h9F, rx, oe);
        chk("oe", 8'h00, {7'h0, oe});
    endtask : t_spi

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_clk_sys);
        #5 i_reset = 1'b0;
        tick(3);
        t_reset();
        t_wel();
        t_lock();
        t_fail();
        t_core();
        t_freeze();
        t_spi();
        summarize();
    end

    // Whole run needs about 21 us; allow a wide margin
    initial begin
        #400000;
        n_fail++;
        summarize();
    end
endmodule : fsr_status_regs_tb_top
